// ==== etg_pkg.sv ====
// Functional notes
// (R1) Hold disabled: target hold requests ignored
// (R2) Hold enabled: hold granted, bus released
// (R3) NMI accept setting passes or drops NMI
// (R4) NMI pends during background monitor, then delivered
// (R5) Realtime-only refuses monitor-break commands
// (R6) Reset enabled: honour reset, restart from vector
// (R7) Reset disabled: target reset ignored
// (R8) Background monitor ignores target reset always
// (R9) Trace setting includes or excludes internal DMA
// (R10) Clock select internal 12.5 MHz or target
// (R11) Target clock 4-25 or 4-32 MHz
// (R12) Clock select change resets emulator
// (R13) Bus width 8 or 16 bits
// (R14) Target width pin ignored completely
// (R15) Bus width change resets emulator
// (R16) Monitor background/foreground; 2K-aligned 20-bit base
// (R17) Monitor select change resets emulator
package etg_pkg;

	localparam logic [3:0] ADDR_CONFIG    = 4'h0;
	localparam logic [3:0] ADDR_MON_BASE  = 4'h1;
	localparam logic [3:0] ADDR_STATUS    = 4'h2;
	localparam logic [3:0] ADDR_CMD       = 4'h3;

	localparam int BIT_HOLD_EN    = 0;
	localparam int BIT_NMI_EN     = 1;
	localparam int BIT_RT_ONLY    = 2;
	localparam int BIT_RST_EN     = 3;
	localparam int BIT_TRACE_DMA  = 4;
	localparam int BIT_CLK_EXT    = 5;
	localparam int BIT_BUS8       = 6;
	localparam int BIT_MON_FG     = 7;

	// Defaults: hold, nmi, reset, trace on; internal clock, 16 bit, background
	localparam logic [7:0] CONFIG_RESET   = 8'h1B;
	localparam logic [8:0] MON_BASE_RESET = 9'h000;
	localparam int         MON_ALIGN_BITS = 11;

	localparam int  CLK_HZ           = 40000000;
	localparam int  INT_CLK_HZ       = 12500000;
	// Internal 12.5 MHz clock as a phase accumulator (5/16 of clk)
	localparam logic [3:0] INT_CLK_STEP = 4'(INT_CLK_HZ * 16 / CLK_HZ);
	localparam int  RESET_HOLD_CYC   = 4;
	localparam logic [2:0] RESET_HOLD = 3'(RESET_HOLD_CYC);

	typedef struct packed {
		logic [15:0] rdata;
		logic        hold_ack;
		logic        bus_release;
		logic        core_hold;
		logic        core_nmi;
		logic        core_reset;
		logic        trace_dma;
		logic        bus_16;
		logic        mon_fg;
		logic        clk_ext;
		logic        cmd_ok;
		logic        cmd_refused;
	} etg_out_type;

	typedef struct packed {
		logic hold_req;
		logic nmi;
		logic reset;
		logic width_pin;
	} etg_pins_type;

endpackage

// ==== etg_sync.sv ====
`timescale 1ns/1ps
module etg_sync
	import etg_pkg::*;
(
	// Clock
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Pin in, filtered level out
	input  wire logic       din,
	output logic            dout
);
	typedef struct packed {
		logic [2:0] sh;
		logic       q;
	} etg_sync_type;

	etg_sync_type s_r;
	etg_sync_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.sh = {s_r.sh[1:0], din};
		if (s_r.sh[1] == s_r.sh[2]) begin
			s_nxt.q = s_r.sh[2];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign dout = s_r.q;
endmodule

// ==== etg_clkgen.sv ====
`timescale 1ns/1ps
module etg_clkgen
	import etg_pkg::*;
(
	// Clock
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Core clock enable from internal or target source
	input  wire logic       sel_ext,
	input  wire logic       ext_tick,
	output logic            core_tick
);
	typedef struct packed {
		logic [3:0] acc;
		logic       prev;
		logic       tick;
	} etg_clk_type;

	etg_clk_type s_r;
	etg_clk_type s_nxt;
	logic [4:0]  sum;

	always_comb begin
		s_nxt = s_r;
		sum = {1'b0, s_r.acc} + {1'b0, INT_CLK_STEP};
		s_nxt.acc = sum[3:0];
		s_nxt.prev = ext_tick;
		// Target clock gives one tick per rising edge, not a level
		s_nxt.tick = sel_ext ? (ext_tick && !s_r.prev) : sum[4]; // R10
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign core_tick = s_r.tick;
endmodule

// ==== etg_top.sv ====
`timescale 1ns/1ps
module etg_top
	import etg_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// Register port
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [15:0]      rdata,
	// Target pins
	input  wire logic        tgt_hold_req,
	input  wire logic        tgt_nmi,
	input  wire logic        tgt_reset_n,
	input  wire logic        target_width_pin,
	input  wire logic        tgt_clk_tick,
	// Emulation core side
	input  wire logic        core_in_monitor,
	input  wire logic        core_hold_ack,
	input  wire logic        core_dma_cycle,
	input  wire logic        core_vector_fetch,
	output logic             hold_ack,
	output logic             bus_release,
	output logic             core_hold,
	output logic             core_nmi,
	output logic             core_reset,
	output logic             core_tick,
	output logic             trace_dma_en,
	output logic             trace_dma_strobe,
	output logic             bus_16,
	output logic             mon_fg,
	output logic [19:0]      mon_base,
	output logic             clk_ext,
	// Monitor-break command handshake
	input  wire logic        brk_cmd,
	output logic             brk_go,
	output logic             brk_refused
);
	typedef enum logic [2:0] {
		RS_RUN  = 3'b001,
		RS_TRST = 3'b010,
		RS_CRST = 3'b100
	} etg_rst_type;

	typedef struct packed {
		logic [7:0]  cfg;
		logic [8:0]  base;
		etg_rst_type rst_st;
		logic [2:0]  rcnt;
		logic        nmi_prev;
		logic        nmi_pend;
		logic        nmi_out;
		logic        hold_out;
		logic        hack_out;
		logic        rel_out;
		logic        reset_out;
		logic        trace_str;
		logic        go;
		logic        refused;
		logic        refused_sticky;
		logic        bus16_out;
		logic [15:0] rdata;
	} etg_state_type;

	etg_state_type s_r;
	etg_state_type s_nxt;
	logic          hold_s;
	logic          nmi_s;
	logic          rst_s;
	logic          tick_w;
	logic          width_unused;

	etg_sync u_sync_hold (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.din   (tgt_hold_req),
		.dout  (hold_s)
	);

	etg_sync u_sync_nmi (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.din   (tgt_nmi),
		.dout  (nmi_s)
	);

	etg_sync u_sync_rst (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.din   (~tgt_reset_n),
		.dout  (rst_s)
	);

	etg_sync u_sync_tick (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.din   (tgt_clk_tick),
		.dout  (tick_w)
	);

	etg_clkgen u_clk (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.sel_ext   (s_r.cfg[BIT_CLK_EXT]),
		.ext_tick  (tick_w),
		.core_tick (core_tick)
	);

	// Width pin has no effect on anything
	assign width_unused = target_width_pin; // R14

	always_comb begin
		logic [7:0] newcfg;
		logic       cfg_wr;
		logic       nmi_edge;
		logic       bg_mon;
		newcfg = wdata[7:0];
		cfg_wr = wr && (addr == ADDR_CONFIG);
		bg_mon = core_in_monitor && !s_r.cfg[BIT_MON_FG];
		nmi_edge = nmi_s && !s_r.nmi_prev;
		s_nxt = s_r;
		s_nxt.nmi_prev = nmi_s;
		s_nxt.go = 1'b0;
		s_nxt.refused = 1'b0;
		s_nxt.trace_str = s_r.cfg[BIT_TRACE_DMA] && core_dma_cycle; // R9
		s_nxt.rdata = '0;

		if (cfg_wr) begin
			s_nxt.cfg = newcfg; // R13
			if (newcfg[BIT_CLK_EXT] != s_r.cfg[BIT_CLK_EXT] // R12
				|| newcfg[BIT_BUS8] != s_r.cfg[BIT_BUS8] // R15
				|| newcfg[BIT_MON_FG] != s_r.cfg[BIT_MON_FG]) begin // R17
				s_nxt.rst_st = RS_CRST;
				s_nxt.rcnt = RESET_HOLD;
			end
		end
		if (wr && addr == ADDR_MON_BASE) begin
			s_nxt.base = wdata[8:0]; // R16
		end
		s_nxt.bus16_out = !s_nxt.cfg[BIT_BUS8]; // R13

		// Hold is a passthrough to the core only when enabled
		s_nxt.hold_out = s_r.cfg[BIT_HOLD_EN] && hold_s; // R1 R2
		s_nxt.hack_out = s_r.cfg[BIT_HOLD_EN] && hold_s && core_hold_ack; // R2
		s_nxt.rel_out = s_nxt.hack_out; // R2

		// NMI: latch edge, deliver only outside background monitor
		if (s_r.cfg[BIT_NMI_EN] && nmi_edge) begin // R3
			s_nxt.nmi_pend = 1'b1;
		end
		if (!s_r.cfg[BIT_NMI_EN]) begin
			s_nxt.nmi_pend = 1'b0; // R3
		end
		s_nxt.nmi_out = 1'b0;
		if (s_r.nmi_pend && !bg_mon && !(s_r.cfg[BIT_NMI_EN] && nmi_edge)) begin // R4
			s_nxt.nmi_out = 1'b1;
			s_nxt.nmi_pend = 1'b0;
		end

		// Break commands
		if (brk_cmd) begin
			if (s_r.cfg[BIT_RT_ONLY]) begin // R5
				s_nxt.refused = 1'b1;
				s_nxt.refused_sticky = 1'b1;
			end else begin
				s_nxt.go = 1'b1;
			end
		end

		unique case (s_r.rst_st)
			RS_RUN: begin
				if (s_r.cfg[BIT_RST_EN] && rst_s && !bg_mon) begin // R6 R7 R8
					s_nxt.rst_st = RS_TRST;
				end
			end
			RS_TRST: begin
				if (!rst_s) begin // R6
					s_nxt.rst_st = RS_RUN;
				end
			end
			RS_CRST: begin
				if (s_r.rcnt == 3'h0) begin
					s_nxt.rst_st = RS_RUN;
				end else begin
					s_nxt.rcnt = s_r.rcnt - 3'h1;
				end
			end
			default: begin
				s_nxt.rst_st = RS_RUN;
			end
		endcase
		s_nxt.reset_out = (s_nxt.rst_st != RS_RUN);

		if (rd) begin
			unique case (addr)
				ADDR_CONFIG: s_nxt.rdata = {8'h00, s_r.cfg};
				ADDR_MON_BASE: s_nxt.rdata = {7'h00, s_r.base};
				ADDR_STATUS: s_nxt.rdata = {8'h00, s_r.refused_sticky, s_r.nmi_pend,
					s_r.reset_out, s_r.hold_out, s_r.rst_st, core_vector_fetch};
				default: s_nxt.rdata = '0;
			endcase
			if (addr == ADDR_STATUS) begin
				s_nxt.refused_sticky = s_nxt.refused;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.cfg <= CONFIG_RESET;
			s_r.base <= MON_BASE_RESET;
			s_r.rst_st <= RS_CRST;
			s_r.rcnt <= RESET_HOLD;
			s_r.reset_out <= 1'b1;
			s_r.bus16_out <= !CONFIG_RESET[BIT_BUS8];
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
	assign hold_ack = s_r.hack_out;
	assign bus_release = s_r.rel_out;
	assign core_hold = s_r.hold_out;
	assign core_nmi = s_r.nmi_out;
	assign core_reset = s_r.reset_out;
	assign trace_dma_en = s_r.cfg[BIT_TRACE_DMA];
	assign trace_dma_strobe = s_r.trace_str;
	assign bus_16 = s_r.bus16_out;
	assign mon_fg = s_r.cfg[BIT_MON_FG];
	assign mon_base = {s_r.base, {MON_ALIGN_BITS{1'b0}}}; // R16
	assign clk_ext = s_r.cfg[BIT_CLK_EXT];
	assign brk_go = s_r.go;
	assign brk_refused = s_r.refused;
endmodule

// ==== etg_top_props.sv ====
`timescale 1ns/1ps
module etg_top_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic brk_cmd,
	input wire logic brk_go,
	input wire logic brk_refused,
	input wire logic hold_ack,
	input wire logic bus_release,
	input wire logic core_hold,
	input wire logic core_reset,
	input wire logic core_nmi,
	input wire logic core_in_monitor,
	input wire logic mon_fg,
	input wire logic bus_16,
	input wire logic clk_ext,
	input wire logic trace_dma_strobe,
	input wire logic core_dma_cycle
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_brk; brk_cmd |=> brk_go ^ brk_refused; endproperty
	a_brk: assert property (p_brk) else $error("break answer missing");
	property p_hold; hold_ack |-> core_hold && bus_release; endproperty
	a_hold: assert property (p_hold) else $error("hold grant alone");
	property p_clk; $changed(clk_ext) |-> ##1 core_reset [*4]; endproperty
	a_clk: assert property (p_clk) else $error("clock switch no reset");
	property p_bus; $changed(bus_16) |-> ##1 core_reset [*4]; endproperty
	a_bus: assert property (p_bus) else $error("width switch no reset");
	property p_mon; $changed(mon_fg) |-> ##1 core_reset [*4]; endproperty
	a_mon: assert property (p_mon) else $error("monitor switch no reset");
	property p_nmi; core_nmi |=> !core_nmi; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi pulse too long");
	property p_nmi_bg; core_nmi && !mon_fg |-> !$past(core_in_monitor); endproperty
	a_nmi_bg: assert property (p_nmi_bg) else $error("nmi in monitor");
	property p_dma;
		trace_dma_strobe |-> $past(core_dma_cycle) || $past(core_dma_cycle, 2);
	endproperty
	a_dma: assert property (p_dma) else $error("trace without dma");
endmodule
bind etg_top etg_top_props etg_top_props_inst (.*);

// ==== etg_target.sv ====
`timescale 1ns/1ps
module etg_target (
	// Clock
	input wire logic clk,
	// Target pins
	output logic     tgt_hold_req,
	output logic     tgt_nmi,
	output logic     tgt_reset_n,
	output logic     target_width_pin,
	output logic     tgt_clk_tick
);
	logic [1:0] div_r = 2'h0;
	initial {tgt_hold_req, tgt_nmi, tgt_reset_n, target_width_pin} = 4'h2;
	// Board clock of 10 MHz
	always @(posedge clk) div_r <= div_r + 2'h1;
	assign tgt_clk_tick = div_r[1];
	// Board holds each level at least four clocks
	task automatic set(input logic [3:0] v);
		@(posedge clk);
		{tgt_hold_req, tgt_nmi, tgt_reset_n, target_width_pin} <= v;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ==== emulator_target_signal_gating_bench.sv ====
`timescale 1ns/1ps
module emulator_target_signal_gating_bench;
	import etg_pkg::*;
	logic        clk, rst_n, ce, wr, rd;
	logic        brk_cmd, core_in_monitor, core_hold_ack;
	logic        core_dma_cycle, core_vector_fetch;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, d;
	logic [19:0] mon_base;
	logic        tgt_hold_req, tgt_nmi, tgt_reset_n, target_width_pin, tgt_clk_tick;
	logic        hold_ack, bus_release, core_hold, core_nmi, core_reset, core_tick;
	logic        trace_dma_en, trace_dma_strobe, bus_16, mon_fg, clk_ext, brk_go, brk_refused;
	logic [7:0]  h [7];
	logic [6:0]  o;
	int          n_fail = 0, tests_run = 0;
	// {resets, {trace, bus_16, mon_fg, clk_ext}, config}
	logic [12:0] rows [6] = '{13'h0C1B, 13'h0400, 13'h1BFF, 13'h1855, 13'h17AA, 13'h1C1B};
	etg_top etg_top_inst (.*);
	etg_target etg_target_inst (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [19:0] g, e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		{addr, wdata, wr} <= {a, v, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk);
		{addr, rd} <= {a, 1'b1};
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Counts high cycles of seven outputs, sampling just after each edge
	task automatic cnt(input int n);
		h = '{default: 8'h00};
		repeat (n) begin
			#1 o = {core_tick, trace_dma_strobe, brk_refused, brk_go, hold_ack, core_reset, core_nmi};
			for (int i = 0; i < 7; i++) h[i] = h[i] + 8'(o[i]);
			@(posedge clk);
		end
	endtask
	task automatic strike(input int k);
		@(posedge clk);
		if (k != 0) core_dma_cycle <= 1'b1;
		else brk_cmd <= 1'b1;
		@(posedge clk);
		{core_dma_cycle, brk_cmd} <= 2'b00;
		cnt(4);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		{rst_n, ce, wr, rd, brk_cmd, core_in_monitor, core_hold_ack} <= 7'h20;
		{core_dma_cycle, core_vector_fetch, addr, wdata} <= 22'h000000;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		cnt(10);
		chk(h[1], 8'(RESET_HOLD_CYC + 1));
		rreg(ADDR_CONFIG);
		chk(d, 16'(CONFIG_RESET));
		$display("reset test done");
		foreach (rows[i]) begin
			wreg(ADDR_CONFIG, {8'h00, rows[i][7:0]});
			cnt(12);
			chk(h[1], rows[i][12] ? 8'(RESET_HOLD_CYC + 1) : 8'h00);
			chk({trace_dma_en, bus_16, mon_fg, clk_ext}, rows[i][11:8]);
			rreg(ADDR_CONFIG);
			chk(d, {8'h00, rows[i][7:0]});
		end
		cnt(16);
		chk(h[6], 8'h05);
		wreg(ADDR_CONFIG, 16'h003B);
		cnt(4);
		cnt(16);
		chk(h[6], 8'h04);
		wreg(ADDR_CONFIG, 16'h001B);
		$display("config test done");
		core_hold_ack <= 1'b1;
		etg_target_inst.set(4'hA);
		cnt(6);
		chk({hold_ack, bus_release, core_hold}, 3'h7);
		wreg(ADDR_CONFIG, 16'h001A);
		cnt(6);
		chk({hold_ack, bus_release, core_hold}, 3'h0);
		etg_target_inst.set(4'h2);
		wreg(ADDR_CONFIG, 16'h001B);
		core_in_monitor <= 1'b1;
		etg_target_inst.set(4'h6);
		etg_target_inst.set(4'h2);
		cnt(8);
		chk(h[0], 8'h00);
		core_in_monitor <= 1'b0;
		cnt(8);
		chk(h[0], 8'h01);
		wreg(ADDR_CONFIG, 16'h0019);
		etg_target_inst.set(4'h6);
		etg_target_inst.set(4'h2);
		cnt(8);
		chk(h[0], 8'h00);
		wreg(ADDR_CONFIG, 16'h001B);
		core_in_monitor <= 1'b1;
		etg_target_inst.set(4'h0);
		etg_target_inst.set(4'h2);
		cnt(8);
		chk(h[1], 8'h00);
		core_in_monitor <= 1'b0;
		etg_target_inst.set(4'h0);
		cnt(4);
		chk(core_reset, 1'b1);
		etg_target_inst.set(4'h2);
		cnt(12);
		chk(core_reset, 1'b0);
		wreg(ADDR_CONFIG, 16'h0013);
		etg_target_inst.set(4'h0);
		cnt(6);
		chk(h[1], 8'h00);
		etg_target_inst.set(4'h3);
		cnt(8);
		chk({h[1], bus_16}, 9'h001);
		$display("pin test done");
		wreg(ADDR_CONFIG, 16'h0017);
		strike(0);
		chk({h[3], h[4]}, 16'h0001);
		wreg(ADDR_CONFIG, 16'h001B);
		strike(0);
		chk({h[3], h[4]}, 16'h0100);
		strike(1);
		chk(h[5], 8'h01);
		wreg(ADDR_CONFIG, 16'h000B);
		strike(1);
		chk(h[5], 8'h00);
		wreg(ADDR_MON_BASE, 16'h01A5);
		rreg(ADDR_MON_BASE);
		chk(d, 16'h01A5);
		chk(mon_base, 20'hD2800);
		rreg(4'h3);
		chk(d, 16'h0000);
		core_vector_fetch <= 1'b1;
		rreg(ADDR_STATUS);
		chk(d, 16'h0083);
		core_vector_fetch <= 1'b0;
		rreg(ADDR_STATUS);
		chk(d, 16'h0002);
		ce <= 1'b0;
		wreg(ADDR_MON_BASE, 16'h0003);
		ce <= 1'b1;
		rreg(ADDR_MON_BASE);
		chk(d, 16'h01A5);
		$display("command test done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		cnt(10);
		chk(h[1], 8'(RESET_HOLD_CYC + 1));
		rreg(ADDR_CONFIG);
		chk(d, 16'(CONFIG_RESET));
		$display("mid-run reset test done");
		complete_run();
	end
endmodule
